// ### hw/interrupt_priority_arbiter.sv
`timescale 1ns/1ps
module interrupt_priority_arbiter (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Register port
   input  wire logic [3:0]               reg_addr_i,
   input  wire logic [7:0]               reg_wdata_i,
   input  wire logic                     reg_we_i,
   input  wire logic                     reg_re_i,
   output logic      [7:0]               reg_rdata_o,
   // Interrupt sources
   input  wire intprio_pkg::src_events_t src_i,
   input  wire logic                     nmi_i,
   // CPU side
   output intprio_pkg::grant_t           grant_o,
   input  wire logic                     ack_i,
   input  wire logic                     reti_i
);

   logic [5:0]           en_base_reg;
   logic [7:0]           en_ext_reg;
   logic [5:0]           plo_reg;
   logic [5:0]           phi_reg;
   logic [7:0]           plo_ext_reg;
   logic [7:0]           phi_ext_reg;
   logic [13:0]          pend_reg;
   logic [13:0]          pend_next;
   logic                 nmi_pend_reg;
   logic                 nmi_pend_next;
   logic [4:0]           inserv_reg;
   logic [4:0]           inserv_next;
   logic [7:0]           rdata_reg;
   intprio_pkg::grant_t  grant_reg;
   intprio_pkg::grant_t  grant_next;

   // Register decode
   wire                  wr_en_base  = reg_we_i && (reg_addr_i == intprio_pkg::ADDR_EN_BASE);
   wire                  wr_en_ext   = reg_we_i && (reg_addr_i == intprio_pkg::ADDR_EN_EXT);
   wire                  wr_plo      = reg_we_i && (reg_addr_i == intprio_pkg::ADDR_PLO);
   wire                  wr_phi      = reg_we_i && (reg_addr_i == intprio_pkg::ADDR_PHI);
   wire                  wr_plo_ext  = reg_we_i && (reg_addr_i == intprio_pkg::ADDR_PLO_EXT);
   wire                  wr_phi_ext  = reg_we_i && (reg_addr_i == intprio_pkg::ADDR_PHI_EXT);

   // Source events folded onto vectors
   wire [13:0]           vec_event = {src_i.capture_compare_unit[3],
                                      src_i.capture_compare_unit[2],
                                      src_i.capture_compare_unit[1],
                                      src_i.capture_compare_unit[0],
                                      |src_i.ext6_3,
                                      src_i.ext2,
                                      src_i.sync_serial_channel,
                                      src_i.adc,
                                      src_i.tmr2 | src_i.fdiv | src_i.lin,
                                      src_i.uart,
                                      src_i.tmr1,
                                      src_i.ext1,
                                      src_i.tmr0,
                                      src_i.ext0};

   // Level per vector, high bit above low bit
   wire [13:0]           lvl_hi = {phi_ext_reg, phi_reg};
   wire [13:0]           lvl_lo = {plo_ext_reg, plo_reg};
   wire [13:0]           en_all = {en_ext_reg, en_base_reg};
   wire [27:0]           lvl_vec;

   for (genvar i = 0; i < intprio_pkg::NUM_VEC; i++) begin : g_lvl
      assign lvl_vec[2*i +: 2] = {lvl_hi[i], lvl_lo[i]};
   end

   // Only enabled pending vectors compete
   wire [13:0]           cand = pend_reg & en_all;

   wire                  win_found;
   wire [3:0]            win_index;
   wire [1:0]            win_level;

   poll_order_select u_poll (
      .cand_i  (cand),
      .level_i (lvl_vec),
      .found_o (win_found),
      .index_o (win_index),
      .level_o (win_level)
   );

   // Current running maskable level
   wire                  busy_mask = |inserv_reg[3:0];
   wire [1:0]            cur_level = inserv_reg[3] ? 2'h3 :
                                     inserv_reg[2] ? 2'h2 :
                                     inserv_reg[1] ? 2'h1 : 2'h0;

   wire                  nmi_ok  = nmi_pend_reg && !inserv_reg[intprio_pkg::NMI_SLOT];
   wire                  mask_ok = win_found && !inserv_reg[intprio_pkg::NMI_SLOT] &&
                                   (!busy_mask || (win_level > cur_level));

   // Stale offer hazard: hold off one cycle after any ack or return
   wire                  offer_hold = ack_i || reti_i;

   always_comb begin
      grant_next = '0;
      if (!offer_hold) begin
         if (nmi_ok) begin
            grant_next.valid = 1'b1;
            grant_next.nmi   = 1'b1;
            grant_next.addr  = intprio_pkg::VEC_NMI;
         end else if (mask_ok) begin
            grant_next.valid = 1'b1;
            grant_next.index = win_index;
            grant_next.level = win_level;
            grant_next.addr  = intprio_pkg::vec_addr(win_index);
         end
      end
   end

   // Service start and return
   wire                  take     = ack_i && grant_reg.valid;
   wire                  take_nmi = take && grant_reg.nmi;
   wire                  take_vec = take && !grant_reg.nmi;
   wire [13:0]           clr_vec  = take_vec ? (14'h0001 << grant_reg.index) : 14'h0000;
   wire [4:0]            set_serv = take_nmi ? 5'h10 :
                                    take_vec ? (5'h01 << grant_reg.level) : 5'h00;

   // Return ends the innermost routine: highest bit in service
   function automatic logic [4:0] top_bit(input logic [4:0] v);
      top_bit = 5'h00;
      for (int k = 0; k < 5; k++) begin
         if (v[k]) begin
            top_bit = 5'h01 << k;
         end
      end
   endfunction : top_bit

   wire [4:0]            clr_serv = reti_i ? top_bit(inserv_reg) : 5'h00;

   // New events win over the clear of the same cycle
   assign pend_next     = (pend_reg & ~clr_vec) | vec_event;
   assign nmi_pend_next = (nmi_pend_reg && !take_nmi) || nmi_i;
   assign inserv_next   = (inserv_reg & ~clr_serv) | set_serv;

   // Read mux
   wire [7:0]            rd_mux =
      (reg_addr_i == intprio_pkg::ADDR_EN_BASE) ? {2'h0, en_base_reg} :
      (reg_addr_i == intprio_pkg::ADDR_EN_EXT)  ? en_ext_reg :
      (reg_addr_i == intprio_pkg::ADDR_PLO)     ? {2'h0, plo_reg} :
      (reg_addr_i == intprio_pkg::ADDR_PHI)     ? {2'h0, phi_reg} :
      (reg_addr_i == intprio_pkg::ADDR_PLO_EXT) ? plo_ext_reg :
      (reg_addr_i == intprio_pkg::ADDR_PHI_EXT) ? phi_ext_reg :
      (reg_addr_i == intprio_pkg::ADDR_PEND_LO) ? {nmi_pend_reg, 1'b0, pend_reg[5:0]} :
      (reg_addr_i == intprio_pkg::ADDR_PEND_HI) ? pend_reg[13:6] :
      (reg_addr_i == intprio_pkg::ADDR_INSERV)  ? {3'h0, inserv_reg} : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_base_reg <= intprio_pkg::RST_REG8[5:0];
         en_ext_reg  <= intprio_pkg::RST_REG8;
         plo_reg     <= intprio_pkg::RST_REG8[5:0];
         phi_reg     <= intprio_pkg::RST_REG8[5:0];
         plo_ext_reg <= intprio_pkg::RST_REG8;
         phi_ext_reg <= intprio_pkg::RST_REG8;
      end else begin
         if (wr_en_base) en_base_reg <= reg_wdata_i[5:0];
         if (wr_en_ext)  en_ext_reg  <= reg_wdata_i;
         if (wr_plo)     plo_reg     <= reg_wdata_i[5:0];
         if (wr_phi)     phi_reg     <= reg_wdata_i[5:0];
         if (wr_plo_ext) plo_ext_reg <= reg_wdata_i;
         if (wr_phi_ext) phi_ext_reg <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg     <= 14'h0000;
         nmi_pend_reg <= 1'b0;
         inserv_reg   <= intprio_pkg::RST_INSERV;
         grant_reg    <= '0;
         rdata_reg    <= intprio_pkg::RST_REG8;
      end else begin
         pend_reg     <= pend_next;
         nmi_pend_reg <= nmi_pend_next;
         inserv_reg   <= inserv_next;
         grant_reg    <= grant_next;
         rdata_reg    <= reg_re_i ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign grant_o     = grant_reg;

   // Helpers for the checks below
   logic [13:0] cand_above;
   logic [13:0] cand_before;
   logic [13:0] cand_d;
   logic [13:0] lvl_hi_d;
   logic [13:0] lvl_lo_d;

   // An offer reflects the cycle before it, so its checks look one cycle back
   always_ff @(posedge clk_i) begin
      cand_d   <= cand;
      lvl_hi_d <= lvl_hi;
      lvl_lo_d <= lvl_lo;
   end

   for (genvar i = 0; i < intprio_pkg::NUM_VEC; i++) begin : g_chk
      assign cand_above[i]  = cand[i] && (lvl_vec[2*i +: 2] > win_level);
      assign cand_before[i] = cand[i] && (lvl_vec[2*i +: 2] == win_level) &&
                              (4'(i) < win_index);
   end

   AST_NMI_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
      (nmi_pend_reg && !inserv_reg[4] && !ack_i && !reti_i)
      |=> (grant_o.valid && grant_o.nmi && grant_o.addr == intprio_pkg::VEC_NMI))
      else $error("Pending non-maskable request not offered");

   AST_LEVEL_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
      (grant_o.valid && !grant_o.nmi)
      |-> (grant_o.level == {lvl_hi_d[grant_o.index], lvl_lo_d[grant_o.index]}))
      else $error("Offered level does not match level registers");

   AST_STRICT_ABOVE: assert property (@(posedge clk_i) disable iff (rst_i)
      (grant_o.valid && !grant_o.nmi && busy_mask) |-> (grant_o.level > cur_level))
      else $error("Offer does not outrank running routine");

   AST_TOP_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
      inserv_reg[3] |-> !(grant_o.valid && !grant_o.nmi))
      else $error("Top level routine offered a preemption");

   AST_HIGH_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      win_found |-> (cand_above == 14'h0000))
      else $error("Higher level candidate passed over");

   AST_POLL_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
      win_found |-> (cand_before == 14'h0000))
      else $error("Earlier polled candidate passed over");

   AST_SHARED_VEC: assert property (@(posedge clk_i) disable iff (rst_i)
      (src_i.tmr2 || src_i.fdiv || src_i.lin)
      |=> (pend_reg[intprio_pkg::POS_SHARED_T2] ##0 (intprio_pkg::vec_addr(4'h5) == 16'h002B)))
      else $error("Shared timer vector not pending");

   AST_ENABLE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      (grant_o.valid && !grant_o.nmi) |-> cand_d[grant_o.index])
      else $error("Disabled or idle vector offered");

   AST_PEND_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(pend_reg[0]) |-> $past(ack_i && grant_o.valid && !grant_o.nmi && grant_o.index == 4'h0))
      else $error("Pending request lost without service");

   AST_ACK_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_i && grant_o.valid && !grant_o.nmi) |=> (inserv_reg[$past(grant_o.level)] && !grant_o.valid))
      else $error("Accepted service not recorded");

   AST_VEC_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
      (grant_o.valid && !grant_o.nmi)
      |-> (grant_o.addr == intprio_pkg::VEC_BASE + intprio_pkg::VEC_STEP * {12'h000, grant_o.index}))
      else $error("Offered vector address off its slot");

   AST_NMI_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      (grant_o.valid && !grant_o.nmi) |-> !$past(nmi_ok))
      else $error("Maskable offer beside an eligible non-maskable request");

   AST_NMI_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
      inserv_reg[intprio_pkg::NMI_SLOT] |-> !grant_o.valid)
      else $error("Offer made while non-maskable routine runs");

   AST_DROP_AFTER_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_i || reti_i) |=> !grant_o.valid)
      else $error("Offer not dropped after ack or return");

   AST_PEND_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      (vec_event != 14'h0000)
      |=> ((pend_reg & $past(vec_event)) == $past(vec_event)))
      else $error("Source event not recorded as pending");

   // No ack in the cycle: a stale offer may still be taken as its enable drops
   AST_DISABLED_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
      (((pend_reg & ~en_all) != 14'h0000) && !ack_i)
      |=> ((pend_reg & $past(pend_reg & ~en_all)) == $past(pend_reg & ~en_all)))
      else $error("Disabled pending request lost");

   AST_TOP_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
      (reti_i && !ack_i && inserv_reg[3] && !inserv_reg[intprio_pkg::NMI_SLOT])
      |=> !inserv_reg[3])
      else $error("Return did not end the top level routine");

   AST_GRANT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      (!win_found && !nmi_ok) |=> !grant_o.valid)
      else $error("Offer made with no eligible request");

   AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !reg_re_i |=> (reg_rdata_o == 8'h00))
      else $error("Read data present without a read");

endmodule : interrupt_priority_arbiter

// ### hw/poll_order_select.sv
`timescale 1ns/1ps
module poll_order_select (
   // Candidates and their levels
   input  wire logic [13:0] cand_i,
   input  wire logic [27:0] level_i,
   // Winner
   output logic             found_o,
   output logic [3:0]       index_o,
   output logic [1:0]       level_o
);

   logic [3:0][13:0] at_level;
   logic [3:0][3:0]  first_idx;
   logic [3:0]       found;

   // Lowest index is first in the polling sequence
   function automatic logic [3:0] first_index(input logic [13:0] v);
      first_index = 4'h0;
      for (int k = 13; k >= 0; k--) begin
         if (v[k]) begin
            first_index = 4'(k);
         end
      end
   endfunction : first_index

   for (genvar l = 0; l < 4; l++) begin : g_lvl
      for (genvar i = 0; i < 14; i++) begin : g_vec
         assign at_level[l][i] = cand_i[i] & (level_i[2*i +: 2] == 2'(l));
      end
      assign found[l]     = |at_level[l];
      assign first_idx[l] = first_index(at_level[l]);
   end

   // Highest level first, then polling order within it
   assign found_o = |found;
   assign level_o = found[3] ? 2'h3 :
                    found[2] ? 2'h2 :
                    found[1] ? 2'h1 : 2'h0;
   assign index_o = first_idx[level_o];

endmodule : poll_order_select

// ### include/intprio_pkg.sv
package intprio_pkg;

   // Vector count and layout of the level registers
   localparam int          NUM_VEC       = 14;
   localparam int          NUM_BASE_VEC  = 6;
   localparam int          NUM_EXT_VEC   = 8;
   localparam int          NUM_LEVELS    = 4;
   localparam logic [1:0]  LEVEL_TOP     = 2'h3;
   localparam int          NMI_SLOT      = 4;

   // Register indices on the plain register port
   localparam logic [3:0]  ADDR_EN_BASE  = 4'h0;
   localparam logic [3:0]  ADDR_EN_EXT   = 4'h1;
   localparam logic [3:0]  ADDR_PLO      = 4'h2;
   localparam logic [3:0]  ADDR_PHI      = 4'h3;
   localparam logic [3:0]  ADDR_PLO_EXT  = 4'h4;
   localparam logic [3:0]  ADDR_PHI_EXT  = 4'h5;
   localparam logic [3:0]  ADDR_PEND_LO  = 4'h6;
   localparam logic [3:0]  ADDR_PEND_HI  = 4'h7;
   localparam logic [3:0]  ADDR_INSERV   = 4'h8;

   // Field positions
   localparam int          PEND_NMI_BIT  = 7;

   // Values after reset
   localparam logic [7:0]  RST_REG8      = 8'h00;
   localparam logic [4:0]  RST_INSERV    = 5'h00;

   // Vector addresses
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam logic [15:0] VEC_STEP      = 16'h0008;
   localparam logic [15:0] VEC_NMI       = 16'h0073;

   // Polling positions (0 based) of grouped sources
   localparam int          POS_SHARED_T2 = 5;
   localparam int          POS_EXT_GRP   = 9;

   typedef struct packed {
      logic       ext0;
      logic       tmr0;
      logic       ext1;
      logic       tmr1;
      logic       uart;
      logic       tmr2;
      logic       fdiv;
      logic       lin;
      logic       adc;
      logic       sync_serial_channel;
      logic       ext2;
      logic [3:0] ext6_3;
      logic [3:0] capture_compare_unit;
   } src_events_t;

   typedef struct packed {
      logic        valid;
      logic        nmi;
      logic [3:0]  index;
      logic [1:0]  level;
      logic [15:0] addr;
   } grant_t;

   function automatic logic [15:0] vec_addr(input logic [3:0] idx);
      vec_addr = VEC_BASE + VEC_STEP * {12'h000, idx};
   endfunction : vec_addr

endpackage : intprio_pkg

// ### verification/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Arbiter side
   input  wire intprio_pkg::grant_t grant_i,
   output logic                     ack_o,
   output logic                     reti_o,
   // Bench control
   input  wire logic                slow_i,
   input  wire logic                ret_req_i
);
   logic [1:0] wait_reg;

   // Acks whatever is offered, so a wrong offer shows up as a wrong take
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o    <= 1'b0;
         reti_o   <= 1'b0;
         wait_reg <= 2'h0;
      end else begin
         reti_o <= ret_req_i;
         ack_o  <= 1'b0;
         // No ack beside a return, the arbiter drops its offer then
         if (!grant_i.valid || ack_o || ret_req_i) begin
            wait_reg <= 2'h0;
         end else if (slow_i && wait_reg != 2'h3) begin
            wait_reg <= wait_reg + 2'h1;
         end else begin
            ack_o <= 1'b1;
         end
      end
   end
endmodule : cpu_core_model

// ### verification/interrupt_priority_arbiter_tb.sv
`timescale 1ns/1ps
module interrupt_priority_arbiter_tb;
   localparam int LIMIT = 10000;
   logic                     clk_i;
   logic                     rst_i;
   logic [3:0]               reg_addr;
   logic [7:0]               reg_wdata;
   logic [7:0]               reg_rdata;
   logic                     reg_we;
   logic                     reg_re;
   logic                     re_d;
   logic                     ack;
   logic                     reti;
   logic                     slow;
   logic                     ret_req;
   logic                     nmi;
   intprio_pkg::src_events_t src;
   intprio_pkg::grant_t      grant;
   int                       fails = 0;
   int                       checks = 0;
   int                       takes = 0;
   int                       cyc = 0;
   int                       gq[$];
   logic [7:0]               rq[$];
   logic [1:0]               lvl [14];
   logic [13:0]              en;
   logic [13:0]              mask;

   interrupt_priority_arbiter dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(reg_rdata),
      .src_i(src), .nmi_i(nmi), .grant_o(grant), .ack_i(ack), .reti_i(reti));
   cpu_core_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .grant_i(grant), .ack_o(ack),
      .reti_o(reti), .slow_i(slow), .ret_req_i(ret_req));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic give_verdict;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic check(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t %s mismatch", $time, what);
      end
   endtask : check

   // Watcher: pops the oldest note whenever a result appears
   always @(posedge clk_i) begin : mon
      int g;
      if (re_d) check(reg_rdata === rq.pop_front(), "read data");
      re_d <= reg_re && !rst_i;
      if (!rst_i && ack && grant.valid) begin
         takes++;
         g = (gq.size() > 0) ? gq.pop_front() : -1;
         if (g == 14) check(grant.nmi === 1'b1 && grant.addr === 16'h0073, "nmi grant");
         else check(g >= 0 && grant.nmi === 1'b0 && grant.index === g[3:0] &&
            grant.level === lvl[g] && grant.addr === 16'h0003 + 16'h0008 * g[15:0],
            "grant");
      end
      cyc++;
      if (cyc >= LIMIT) begin
         fails++;
         give_verdict();
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_i);
      reg_we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(e);
      @(posedge clk_i);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_i);
      reg_re <= 1'b0;
   endtask : rd

   task automatic prog;
      logic [13:0] lo;
      logic [13:0] hi;
      logic [7:0]  v [6];
      for (int i = 0; i < 14; i++) begin
         lo[i] = lvl[i][0];
         hi[i] = lvl[i][1];
      end
      v = '{{2'h0, en[5:0]}, en[13:6], {2'h0, lo[5:0]}, {2'h0, hi[5:0]}, lo[13:6], hi[13:6]};
      // Reserved bits written high must read back low
      for (int a = 0; a < 6; a++) wr(4'(a), v[a] | ((a == 1 || a > 3) ? 8'h00 : 8'hC0));
      for (int a = 0; a < 6; a++) rd(4'(a), v[a]);
   endtask : prog

   task automatic fire(input logic [13:0] m, input logic n);
      intprio_pkg::src_events_t s;
      s = '0;
      for (int i = 0; i < 14; i++) begin
         if (m[i]) begin
            case (i)
               0: s.ext0 = 1'b1;
               1: s.tmr0 = 1'b1;
               2: s.ext1 = 1'b1;
               3: s.tmr1 = 1'b1;
               4: s.uart = 1'b1;
               5: s.tmr2 = 1'b1;
               6: s.adc = 1'b1;
               7: s.sync_serial_channel = 1'b1;
               8: s.ext2 = 1'b1;
               9: s.ext6_3[$urandom % 4] = 1'b1;
               default: s.capture_compare_unit[i - 10] = 1'b1;
            endcase
            // Shared vector: any of its three sources
            if (i == 5) {s.tmr2, s.fdiv, s.lin} = 3'h1 << ($urandom % 3);
         end
      end
      @(posedge clk_i);
      src <= s;
      nmi <= n;
      @(posedge clk_i);
      src <= '0;
      nmi <= 1'b0;
   endtask : fire

   task automatic expect_set(input logic [13:0] m, input logic n);
      if (n) gq.push_back(14);
      for (int l = 3; l >= 0; l--)
         for (int i = 0; i < 14; i++)
            if (m[i] && en[i] && lvl[i] == 2'(l)) gq.push_back(i);
   endtask : expect_set

   task automatic take;
      int t0;
      t0 = takes;
      repeat (40) begin
         @(negedge clk_i);
         if (takes != t0) return;
      end
      check(1'b0, "no grant taken");
   endtask : take

   task automatic ret;
      @(posedge clk_i);
      ret_req <= 1'b1;
      @(posedge clk_i);
      ret_req <= 1'b0;
   endtask : ret

   task automatic drain;
      repeat (gq.size()) begin
         take();
         ret();
      end
   endtask : drain

   initial begin
      void'($urandom(32'hEC12));
      rst_i     = 1'b1;
      // Noise on every input under reset, quiet one cycle before release
      reg_addr  = 4'($urandom);
      reg_wdata = 8'($urandom);
      reg_we    = 1'($urandom);
      reg_re    = ~reg_we;
      slow      = 1'($urandom);
      ret_req   = 1'($urandom);
      nmi       = 1'($urandom);
      src       = intprio_pkg::src_events_t'(25'($urandom));
      repeat (19) @(posedge clk_i);
      reg_we  <= 1'b0;
      reg_re  <= 1'b0;
      slow    <= 1'b0;
      ret_req <= 1'b0;
      nmi     <= 1'b0;
      src     <= '0;
      @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
      wr(4'h6, 8'hFF);
      rd(4'h6, 8'h00);
      wr(4'hC, 8'hFF);
      rd(4'hC, 8'h00);
      // First trial: all on one level, pure polling order
      for (int t = 0; t < 6; t++) begin
         en = (t == 0) ? 14'h3FFF : 14'($urandom);
         foreach (lvl[i]) lvl[i] = (t == 0) ? 2'h0 : 2'($urandom);
         slow <= t[0];
         prog();
         mask = (t == 0) ? 14'h3FFF : 14'($urandom);
         expect_set(mask, t[1]);
         fire(mask, t[1]);
         drain();
         mask = mask & ~en;
         en = 14'h3FFF;
         expect_set(mask, 1'b0);
         // CPU held off until all six registers are written and read back
         @(posedge clk_i);
         ret_req <= 1'b1;
         prog();
         ret_req <= 1'b0;
         drain();
      end
      foreach (lvl[i]) lvl[i] = 2'h0;
      {lvl[0], lvl[1], lvl[2], lvl[3], lvl[4]} = {2'h1, 2'h2, 2'h1, 2'h3, 2'h3};
      prog();
      gq.push_back(0);
      fire(14'h0001, 1'b0);
      take();
      gq.push_back(1);
      fire(14'h0006, 1'b0);
      take();
      ret();
      gq.push_back(3);
      fire(14'h0008, 1'b0);
      take();
      fire(14'h0030, 1'b0);
      repeat (12) @(posedge clk_i);
      gq.push_back(14);
      fire(14'h0000, 1'b1);
      take();
      ret();
      gq.push_back(4);
      ret();
      take();
      ret();
      gq.push_back(2);
      gq.push_back(5);
      ret();
      drain();
      for (int a = 6; a < 9; a++) rd(4'(a), 8'h00);
      repeat (4) @(posedge clk_i);
      give_verdict();
   end
endmodule : interrupt_priority_arbiter_tb
